/* File: rtl/olsf_flags.sv */
// Purpose: Over-temperature 2 and line-sense flags with debounce, Avalon-MM slave
// Assumes: Readings come from logic on ref_clk; one-cycle-delayed waitrequest answer
// Notes: Registers reached over Avalon-MM; writes land one edge after the wait ends, on the edge that completes the transfer
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module olsf_flags
    import olsf_pkg::*;
#(
    parameter int DB_A_CYCLES = DB_A_CYC,
    parameter int DB_B_CYCLES = DB_B_CYC,
    parameter int DB_C_CYCLES = DB_C_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Sensor readings
    input wire logic [RD_W-1:0] temp_sensor_2_value,
    input wire logic [RD_W-1:0] line_sense_value,
    // Power good
    input wire logic power_good_chan_a_in,
    input wire logic power_good_chan_b_in,
    output logic power_good_chan_a,
    output logic power_good_chan_b,
    // Flags and interrupt
    output logic overtemp_guard_2_flag,
    output logic line_sense_flag,
    output logic irq
);
    // ==========================================================
    // Decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        hit = (a[ADDR_W-1:WORD_LSB] == idx);
    endfunction

    function automatic logic [CNT_W-1:0] cyc(input int c);
        cyc = (c < 1) ? CNT_W'(1) : CNT_W'(c);
    endfunction

    // ==========================================================
    // Registers and bus
    logic [7:0] ot2_limit_ff, nxt_ot2_limit;
    logic [7:0] ls_trim_ff, nxt_ls_trim;
    logic [7:0] ls_set_ff, nxt_ls_set;
    logic [IRQ_W-1:0] sts_ff, nxt_sts;
    logic [IRQ_W-1:0] mask_ff, nxt_mask;
    logic ack_ff, nxt_ack;
    logic [31:0] rd_ff, nxt_rd;
    logic [IRQ_W-1:0] ev;
    logic [NDB-1:0] flag_ff;
    logic wr_go;

    assign wr_go = write && ack_ff;

    always_comb begin
        nxt_ot2_limit = ot2_limit_ff;
        nxt_ls_trim = ls_trim_ff;
        nxt_ls_set = ls_set_ff;
        nxt_mask = mask_ff;
        nxt_sts = sts_ff;
        nxt_ack = (read || write) && !ack_ff;
        nxt_rd = rd_ff;
        if (wr_go) begin
            if (hit(address, OT2_LIMIT_IDX)) begin
                nxt_ot2_limit = writedata[7:0];
            end
            if (hit(address, LS_TRIM_IDX)) begin
                nxt_ls_trim = writedata[7:0];
            end
            if (hit(address, LS_SET_IDX)) begin
                nxt_ls_set = writedata[7:0];
            end
            if (hit(address, IRQ_MASK_IDX)) begin
                nxt_mask = writedata[IRQ_W-1:0];
            end
            if (hit(address, IRQ_STS_IDX)) begin
                nxt_sts = sts_ff & ~writedata[IRQ_W-1:0];
            end
        end
        nxt_sts = nxt_sts | ev;
        if (read && !ack_ff) begin
            nxt_rd = '0;
            if (hit(address, OT2_LIMIT_IDX)) begin
                nxt_rd[7:0] = ot2_limit_ff;
            end
            if (hit(address, LS_TRIM_IDX)) begin
                nxt_rd[7:0] = ls_trim_ff;
            end
            if (hit(address, LS_SET_IDX)) begin
                nxt_rd[7:0] = ls_set_ff;
            end
            if (hit(address, IRQ_STS_IDX)) begin
                nxt_rd[IRQ_W-1:0] = sts_ff;
            end
            if (hit(address, IRQ_MASK_IDX)) begin
                nxt_rd[IRQ_W-1:0] = mask_ff;
            end
            if (hit(address, FLAG_STATE_IDX)) begin
                nxt_rd[NDB-1:0] = flag_ff;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ot2_limit_ff <= REG_RST;
            ls_trim_ff <= REG_RST;
            ls_set_ff <= REG_RST;
            sts_ff <= '0;
            mask_ff <= '0;
            ack_ff <= 1'b0;
            rd_ff <= '0;
        end else begin
            ot2_limit_ff <= nxt_ot2_limit;
            ls_trim_ff <= nxt_ls_trim;
            ls_set_ff <= nxt_ls_set;
            sts_ff <= nxt_sts;
            mask_ff <= nxt_mask;
            ack_ff <= nxt_ack;
            rd_ff <= nxt_rd;
        end
    end

    assign waitrequest = (read || write) && !ack_ff;
    assign readdata = rd_ff;
    assign irq = |(sts_ff & mask_ff);

    // ==========================================================
    // Comparators
    // Limit LSB is 800 mV / 256 = 3.125 mV; codes 2, 4, 5 give 6.25, 12.5, 15.625 mV
    logic [8:0] ot_limit9;
    logic ot_raw;
    logic [RD_W+7:0] ls_prod;
    logic [RD_W:0] ls_adj;
    logic [RD_W-1:0] ls_trimmed;
    logic [RD_W:0] ls_rel;
    logic [3:0] ls_thr;
    logic ls_raw;

    assign ot_limit9 = {1'b0, ot2_limit_ff};
    assign ot_raw = ot_limit9 > temp_sensor_2_value[RD_W-1 -: 9];
    assign ls_thr = ls_set_ff[THR_MSB:THR_LSB];

    always_comb begin
        ls_prod = (RD_W+8)'(line_sense_value) * (RD_W+8)'(ls_trim_ff[TRIM_MAG_MSB:0]);
        ls_adj = {1'b0, line_sense_value};
        if (ls_trim_ff[TRIM_POL_BIT]) begin
            ls_adj = ls_adj - (RD_W+1)'(ls_prod >> TRIM_SHIFT);
        end else begin
            ls_adj = ls_adj + (RD_W+1)'(ls_prod >> TRIM_SHIFT);
        end
        if (ls_adj[RD_W]) begin
            ls_trimmed = ls_trim_ff[TRIM_POL_BIT] ? '0 : '1;
        end else begin
            ls_trimmed = ls_adj[RD_W-1:0];
        end
        ls_rel = {1'b0, ls_thr, {(RD_W-4){1'b0}}} - (RD_W+1)'(LS_HYST_CNT);
        if (ls_thr == 4'h0) begin
            ls_raw = 1'b0;
        end else if (ls_trimmed[RD_W-1 -: 4] >= ls_thr) begin
            ls_raw = 1'b1;
        end else if (flag_ff[DB_LS] && !ls_rel[RD_W] && ({1'b0, ls_trimmed} >= ls_rel)) begin
            ls_raw = 1'b1;
        end else begin
            ls_raw = 1'b0;
        end
    end

    // ==========================================================
    // Debounce
    logic [NDB-1:0] raw;
    logic [NDB-1:0] prev_ff;
    logic [CNT_W-1:0] lim [NDB];
    logic [CNT_W-1:0] cnt_ff [NDB];
    logic [CNT_W-1:0] ls_lim;

    assign raw = {ls_raw, ls_raw, ot_raw};
    assign lim[DB_LS] = ls_lim;
    assign lim[DB_OT] = cyc(DB_C_CYCLES);
    assign lim[DB_PG] = ls_set_ff[PG_DB_BIT] ? cyc(DB_A_CYCLES) : '0;

    always_comb begin
        unique case (ls_set_ff[DB_SEL_MSB:0])
            DB_SEL_0: ls_lim = '0;
            DB_SEL_A: ls_lim = cyc(DB_A_CYCLES);
            DB_SEL_B: ls_lim = cyc(DB_B_CYCLES);
            default: ls_lim = cyc(DB_C_CYCLES);
        endcase
    end

    for (genvar i = 0; i < NDB; i++) begin : g_db
        logic [CNT_W-1:0] nxt_cnt;
        logic nxt_flag;

        always_comb begin
            nxt_cnt = cnt_ff[i];
            nxt_flag = flag_ff[i];
            if (raw[i] != prev_ff[i]) begin
                nxt_cnt = '0;
            end else if (raw[i] != flag_ff[i]) begin
                if (cnt_ff[i] + CNT_W'(1) >= lim[i]) begin
                    nxt_flag = raw[i];
                    nxt_cnt = '0;
                end else begin
                    nxt_cnt = cnt_ff[i] + CNT_W'(1);
                end
            end else begin
                nxt_cnt = '0;
            end
            if (lim[i] == '0) begin
                nxt_flag = raw[i];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
                cnt_ff[i] <= '0;
                flag_ff[i] <= 1'b0;
                prev_ff[i] <= 1'b0;
            end else begin
                cnt_ff[i] <= nxt_cnt;
                flag_ff[i] <= nxt_flag;
                prev_ff[i] <= raw[i];
            end
        end
    end

    // ==========================================================
    // Outputs and events
    logic [NDB-1:0] flag_d_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            flag_d_ff <= '0;
        end else begin
            flag_d_ff <= flag_ff;
        end
    end

    assign ev[IRQ_OT2] = flag_ff[DB_OT] && !flag_d_ff[DB_OT];
    assign ev[IRQ_LS] = flag_ff[DB_LS] != flag_d_ff[DB_LS];
    assign overtemp_guard_2_flag = flag_ff[DB_OT];
    assign line_sense_flag = flag_ff[DB_LS];
    assign power_good_chan_a = power_good_chan_a_in && (!ls_set_ff[PG_INCL_BIT] || flag_ff[DB_PG]);
    assign power_good_chan_b = power_good_chan_b_in && (!ls_set_ff[PG_INCL_BIT] || flag_ff[DB_PG]);

    // ==========================================================
    // Checks
    sequence ot_held_s;
        (ot_raw == prev_ff[DB_OT]);
    endsequence

    ot_compare_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ot_raw == ({1'b0, ot2_limit_ff} > temp_sensor_2_value[RD_W-1 -: 9]))
        else $error("overtemp compare wrong");
    ot_flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(flag_ff[DB_OT]) |-> $past(ot_raw) && $past(cnt_ff[DB_OT]) == lim[DB_OT] - CNT_W'(1))
        else $error("overtemp flag set early");
    ot_debounce_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ot_held_s ##0 (ot_raw != flag_ff[DB_OT]) ##1 (ot_raw == prev_ff[DB_OT]) |->
        (cnt_ff[DB_OT] == $past(cnt_ff[DB_OT]) + CNT_W'(1)) || (flag_ff[DB_OT] == ot_raw))
        else $error("overtemp count stuck");
    ls_zero_thr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ls_thr == 4'h0) |-> !ls_raw)
        else $error("zero threshold raised flag");
    ls_thr_cmp_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ls_thr != 4'h0 && ls_trimmed[RD_W-1 -: 4] >= ls_thr) |-> ls_raw)
        else $error("threshold compare wrong");
    ls_hyst_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!flag_ff[DB_LS] && ls_trimmed[RD_W-1 -: 4] < ls_thr) |-> !ls_raw)
        else $error("hysteresis on set side");
    ls_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (raw[DB_LS] != prev_ff[DB_LS]) |=> (cnt_ff[DB_LS] == '0) && $stable(flag_ff[DB_LS]) || lim[DB_LS] == '0)
        else $error("debounce not restarted");
    pg_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ls_set_ff[PG_INCL_BIT] && !flag_ff[DB_PG]) |-> !power_good_chan_a && !power_good_chan_b)
        else $error("power good not gated");
    trim_sign_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ls_trim_ff[TRIM_POL_BIT] |-> ls_trimmed <= line_sense_value) and
        (!ls_trim_ff[TRIM_POL_BIT] |-> ls_trimmed >= line_sense_value))
        else $error("trim sign wrong");
endmodule
`default_nettype wire

/* File: inc/olsf_pkg.sv */
// Purpose: Constants for the over-temperature and line-sense flag block
// Assumes: 25 MHz ref_clk, 12-bit sensor readings
// Notes: Register indices; byte address is four times the index
package olsf_pkg;
    // ==========================================================
    // Register map (word index)
    localparam logic [15:0] OT2_LIMIT_IDX = 16'hFE76;
    localparam logic [15:0] LS_TRIM_IDX = 16'hFE77;
    localparam logic [15:0] LS_SET_IDX = 16'hFE78;
    localparam logic [15:0] IRQ_STS_IDX = 16'hFE80;
    localparam logic [15:0] IRQ_MASK_IDX = 16'hFE81;
    localparam logic [15:0] FLAG_STATE_IDX = 16'hFE82;
    localparam int ADDR_W = 18;
    localparam int WORD_LSB = 2;
    // ==========================================================
    // Reset values and fields
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int TRIM_POL_BIT = 7;
    localparam int TRIM_MAG_MSB = 6;
    localparam int PG_INCL_BIT = 7;
    localparam int PG_DB_BIT = 6;
    localparam int THR_MSB = 5;
    localparam int THR_LSB = 2;
    localparam int DB_SEL_MSB = 1;
    localparam int IRQ_OT2 = 0;
    localparam int IRQ_LS = 1;
    localparam int IRQ_W = 2;
    // ==========================================================
    // Scaling
    localparam int RD_W = 12;
    localparam int TRIM_SHIFT = 10;
    localparam int LS_FS_MV = 1600;
    localparam int LS_HYST_MV = 75;
    localparam int LS_HYST_CNT = (LS_HYST_MV * (1 << RD_W)) / LS_FS_MV;
    // ==========================================================
    // Timing
    localparam int CLK_KHZ = 25000;
    localparam int DB_A_US = 2600;
    localparam int DB_B_US = 10400;
    localparam int DB_C_US = 100000;
    localparam int DB_A_CYC = DB_A_US * (CLK_KHZ / 1000);
    localparam int DB_B_CYC = DB_B_US * (CLK_KHZ / 1000);
    localparam int DB_C_CYC = DB_C_US * (CLK_KHZ / 1000);
    localparam int CNT_W = 22;
    localparam logic [1:0] DB_SEL_0 = 2'h0;
    localparam logic [1:0] DB_SEL_A = 2'h1;
    localparam logic [1:0] DB_SEL_B = 2'h2;
    localparam int NDB = 3;
    localparam int DB_OT = 0;
    localparam int DB_LS = 1;
    localparam int DB_PG = 2;
endpackage

/* File: dv/olsf_sensor_model.sv */
// Purpose: Far-side model of the temperature sensor and line divider
// Assumes: Bench sets the target codes
// Notes: Readings land one edge after the target
`timescale 1ns/10ps
`default_nettype none
module olsf_sensor_model
    import olsf_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Targets
    input wire logic [RD_W-1:0] temp_tgt,
    input wire logic [RD_W-1:0] line_tgt,
    // Readings
    output logic [RD_W-1:0] temp_sensor_2_value,
    output logic [RD_W-1:0] line_sense_value
);
    // ==========================================================
    // Converted readings
    always_ff @(posedge ref_clk) begin
        temp_sensor_2_value <= temp_tgt;
        line_sense_value <= line_tgt;
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the flag block
// Assumes: Debounce parameters shortened to 5, 10 and 20
// Notes: Reads are checked by a monitor against a queue
`timescale 1ns/10ps
`default_nettype none
module tb;
    import olsf_pkg::*;
    localparam int LA = 5;
    localparam int LB = 10;
    localparam int LC = 20;
    localparam logic [15:0] FS = FLAG_STATE_IDX;
    logic ref_clk, rst_b, read, write, waitrequest, irq;
    logic pga_in, pgb_in, pga, pgb, ot_flag, ls_flag;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata;
    logic [RD_W-1:0] t_tgt, l_tgt, t_val, l_val;
    logic [63:0] q[$];
    logic [63:0] e;
    logic [7:0] r, lv;
    int mismatches, n_compared;
    int lim[4] = '{0, LA, LB, LC};
    logic [15:0] rl[7] = '{OT2_LIMIT_IDX, LS_TRIM_IDX, LS_SET_IDX, IRQ_STS_IDX, IRQ_MASK_IDX, FS, 16'hFE90};
    logic [31:0] tbl[6] = '{32'h00800001, 32'h00750001, 32'h0073F000, 32'h007FF000, 32'h7F7F0001, 32'hFF810000};
    olsf_sensor_model sen (.ref_clk(ref_clk), .temp_tgt(t_tgt), .line_tgt(l_tgt),
        .temp_sensor_2_value(t_val), .line_sense_value(l_val));
    olsf_flags #(.DB_A_CYCLES(LA), .DB_B_CYCLES(LB), .DB_C_CYCLES(LC)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .temp_sensor_2_value(t_val), .line_sense_value(l_val),
        .power_good_chan_a_in(pga_in), .power_good_chan_b_in(pgb_in), .power_good_chan_a(pga),
        .power_good_chan_b(pgb), .overtemp_guard_2_flag(ot_flag), .line_sense_flag(ls_flag), .irq(irq));
    // ==========================================================
    // Compare and bus tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_compared++;
        if ((got & m) !== (exp & m)) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pin(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp}, 32'h1);
    endtask
    task automatic bus(input logic we, input logic [15:0] idx, input logic [31:0] d, input logic [31:0] m);
        @(posedge ref_clk);
        if (!we) q.push_back({m, d});
        address <= {idx, 2'b00};
        read <= !we;
        write <= we;
        writedata <= d;
        do begin
            @(posedge ref_clk);
        end while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, {24'h0, d}, 32'h0);
    endtask
    task automatic rd(input int k, input logic [15:0] idx, input logic [31:0] d, input logic [31:0] m);
        repeat (k) @(posedge ref_clk);
        bus(1'b0, idx, d, m);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and read monitor
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #800000;
        mismatches++;
        close_out();
    end
    always @(posedge ref_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0 && q.size() > 0) begin
            e = q.pop_front();
            cmp(readdata, e[31:0], e[63:32]);
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        t_tgt = 12'hFFF;
        l_tgt = 12'h000;
        pga_in = 1'b1;
        pgb_in = 1'b0;
        void'($urandom(10491));
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        foreach (rl[i]) rd(0, rl[i], 32'h0, 32'hFFFFFFFF);
        r = 8'($urandom);
        wr(LS_TRIM_IDX, r);
        rd(0, LS_TRIM_IDX, {24'h0, r}, 32'hFFFFFFFF);
        wr(LS_TRIM_IDX, 8'h00);
        wr(IRQ_MASK_IDX, 8'h01);
        lv = 8'(2 + $urandom % 252);
        wr(OT2_LIMIT_IDX, lv);
        wr(IRQ_STS_IDX, 8'h03);
        t_tgt <= {1'b0, lv - 8'h01, r[2:0]};
        rd(LC - 4, FS, 32'h0, 32'h1);
        rd(LC + 6, FS, 32'h1, 32'h1);
        pin(ot_flag, 1'b1);
        pin(irq, 1'b1);
        rd(0, IRQ_STS_IDX, 32'h1, 32'h3);
        wr(IRQ_STS_IDX, 8'h01);
        @(posedge ref_clk);
        pin(irq, 1'b0);
        t_tgt <= {1'b0, lv, 3'h0};
        rd(LC + 8, FS, 32'h0, 32'h1);
        wr(OT2_LIMIT_IDX, 8'hF4);
        t_tgt <= 12'h800;
        rd(LC + 8, FS, 32'h0, 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(LS_SET_IDX, 8'(8'h20 | c));
            l_tgt <= 12'h900;
            if (c > 0) rd(lim[c] - 4, FS, 32'h0, 32'h2);
            rd(lim[c] + 8, FS, 32'h2, 32'h2);
            pin(ls_flag, 1'b1);
            l_tgt <= 12'h600;
            rd(lim[c] + 8, FS, 32'h0, 32'h2);
        end
        wr(LS_SET_IDX, 8'h22);
        l_tgt <= 12'h900;
        repeat (4) @(posedge ref_clk);
        l_tgt <= 12'h600;
        rd(LB + 8, FS, 32'h0, 32'h2);
        pin(irq, 1'b0);
        rd(0, IRQ_STS_IDX, 32'h2, 32'h2);
        wr(IRQ_MASK_IDX, 8'h03);
        @(posedge ref_clk);
        pin(irq, 1'b1);
        wr(IRQ_STS_IDX, 8'h02);
        @(posedge ref_clk);
        pin(irq, 1'b0);
        wr(LS_SET_IDX, 8'h20);
        foreach (tbl[i]) begin
            wr(LS_TRIM_IDX, tbl[i][31:24]);
            l_tgt <= tbl[i][23:12];
            rd(8, FS, {30'h0, tbl[i][0], 1'b0}, 32'h2);
        end
        wr(LS_TRIM_IDX, 8'h00);
        wr(LS_SET_IDX, 8'h00);
        l_tgt <= 12'hFFF;
        rd(8, FS, 32'h0, 32'h2);
        wr(LS_SET_IDX, 8'hA0);
        l_tgt <= 12'h900;
        pgb_in <= 1'($urandom);
        rd(10, FS, 32'h2, 32'h2);
        pin(pga, 1'b1);
        pin(pgb, pgb_in);
        l_tgt <= 12'h600;
        rd(10, FS, 32'h0, 32'h2);
        pin(pga, 1'b0);
        pin(pgb, 1'b0);
        wr(LS_SET_IDX, 8'h20);
        @(posedge ref_clk);
        pin(pga, 1'b1);
        wr(LS_SET_IDX, 8'hE0);
        l_tgt <= 12'h900;
        repeat (2) @(posedge ref_clk);
        pin(pga, 1'b0);
        rd(LA + 4, FS, 32'h6, 32'h6);
        pin(pga, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
